// [rtl/trace_capture_defines.vh]
`ifndef TRACE_CAPTURE_DEFINES_VH
`define TRACE_CAPTURE_DEFINES_VH

// Buffer and history sizes
`define TR_FIFO_DEPTH 16
`define TR_FIFO_AW 4
`define TR_HIST_DEPTH 8
`define TR_HIST_AW 3
// Free slots kept when the CPU is held
`define TR_STALL_SLACK 5'h03
// System bus carries 28 address bits
`define TR_SYS_ADDR_W 28
`define TR_SYS_MASK 32'h0FFFFFFF
// Instruction length, for completion-type exception sources
`define TR_INSTR_BYTES 32'h00000002

// Queued entry layout: type, flags, address, data
`define TR_REC_W 72
`define TR_TYPE_MSB 71
`define TR_TYPE_LSB 68
`define TR_FLAG_MSB 65
`define TR_FLAG_LSB 64
`define TR_ADDR_MSB 63
`define TR_ADDR_LSB 32
`define TR_DATA_MSB 31
`define TR_DATA_LSB 0

// Record type codes, first nibble on the port
`define TR_T_BRANCH 4'h1
`define TR_T_DEST 4'h2
`define TR_T_RD 4'h3
`define TR_T_WR 4'h4
`define TR_T_STRACE 4'h5
`define TR_T_LOST 4'h6
`define TR_T_WAIT 4'h7

// Address size codes
`define TR_SZ_32 2'h0
`define TR_SZ_16 2'h1
`define TR_SZ_8 2'h2
`define TR_SZ_4 2'h3

`endif

// [rtl/trace_fifo.v]
`timescale 1ns/1ns
// Record queue between the event sources and the port serializer
module trace_fifo #(
   parameter W = 72,
   parameter D = 16,
   parameter AW = 4
)(
   input wire clk,
   input wire rst,
   input wire in_valid,
   input wire [W-1:0] in_data,
   output wire in_ready,
   output wire out_valid,
   output wire [W-1:0] out_data,
   input wire out_ready,
   output wire [AW:0] level
);
   reg [W-1:0] mem [0:D-1];
   reg [AW-1:0] wr_ff;
   reg [AW-1:0] rd_ff;
   reg [AW:0] cnt_ff;
   wire push;
   wire pop;

   // Full and empty straight from the occupancy count
   assign in_ready = (cnt_ff != D[AW:0]);
   assign out_valid = (cnt_ff != {(AW+1){1'b0}});
   assign out_data = mem[rd_ff];
   assign level = cnt_ff;
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // Storage has no reset; only pointers need one
   always @(posedge clk)
   begin
      if (push)
         mem[wr_ff] <= in_data;
   end

   // Pointers wrap modulo D
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wr_ff <= {AW{1'b0}};
         rd_ff <= {AW{1'b0}};
         cnt_ff <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
            wr_ff <= (wr_ff == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ff + 1'b1;
         if (pop)
            rd_ff <= (rd_ff == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ff + 1'b1;
         if (push & ~pop)
            cnt_ff <= cnt_ff + 1'b1;
         else if (pop & ~push)
            cnt_ff <= cnt_ff - 1'b1;
      end
   end
endmodule // trace_fifo

// [rtl/trace_capture.v]
`timescale 1ns/1ns
`include "trace_capture_defines.vh"

// Function
// - Two window channels, each own address range
// - Window qualifies read, write, or both
// - Local bus source sees every CPU cycle
// - System bus source skips CPU cache hits
// - System bus addresses keep 28 bits only
// - Cache fills seen only via system bus
// - Software trace records PC plus one register
// - Branch gives source record then destination record
// - Realtime drop emits lost-data record
// - Non-realtime stall emits CPU-wait record
// - Branch source sent as difference
// - Window address sent as difference
// - Send 16, 8 or 4 low bits
// - History keeps last eight branches, overwriting oldest
// - Zero-displacement conditional branches not traced
// - Reset vector jump not traced
// - Completion exception source is next address
// - Non-realtime holds CPU while 3 or fewer queue slots are free
// - Realtime never stalls, drops new data
module trace_capture #(
   parameter FIFO_DEPTH = `TR_FIFO_DEPTH,
   parameter FIFO_AW = `TR_FIFO_AW
)(
   input wire clk,
   input wire rst,
   input wire trace_port_clock,
   input wire realtime_mode,
   input wire branch_trace_en,
   input wire sw_trace_en,
   input wire int_trace_en,
   input wire [1:0] win_en,
   input wire [1:0] win_rd_en,
   input wire [1:0] win_wr_en,
   input wire [1:0] win_sys_bus,
   input wire [63:0] win_lo,
   input wire [63:0] win_hi,
   input wire br_valid,
   input wire [31:0] br_src,
   input wire [31:0] br_dst,
   input wire br_zero_disp_cond,
   input wire br_reset,
   input wire br_compl_exc,
   input wire sw_valid,
   input wire [31:0] sw_pc,
   input wire [31:0] sw_reg,
   input wire lb_valid,
   input wire lb_write,
   input wire lb_fill,
   input wire [31:0] lb_addr,
   input wire [31:0] lb_data,
   input wire sb_valid,
   input wire sb_write,
   input wire sb_cache_hit,
   input wire [27:0] sb_addr,
   input wire [31:0] sb_data,
   input wire [2:0] hist_idx,
   output reg [31:0] hist_src,
   output reg [31:0] hist_dst,
   output reg [3:0] trace_output_port,
   output reg trace_sync,
   output reg cpu_stall
);
   // Narrowest field that still rebuilds the address
   function [1:0] size_code;
      input [31:0] a;
      input [31:0] p;
      begin
         if (a[31:4] == p[31:4])
            size_code = `TR_SZ_4;
         else if (a[31:8] == p[31:8])
            size_code = `TR_SZ_8;
         else if (a[31:16] == p[31:16])
            size_code = `TR_SZ_16;
         else
            size_code = `TR_SZ_32;
      end
   endfunction

   // Nibbles sent for a size code
   function [3:0] addr_nibs;
      input [1:0] s;
      begin
         case (s)
            `TR_SZ_4: addr_nibs = 4'h1;
            `TR_SZ_8: addr_nibs = 4'h2;
            `TR_SZ_16: addr_nibs = 4'h4;
            default: addr_nibs = 4'h8;
         endcase
      end
   endfunction

   reg ptc_s1_ff;
   reg ptc_s2_ff;
   reg ptc_s3_ff;
   wire tick;
   reg [31:0] hsrc_mem [0:`TR_HIST_DEPTH-1];
   reg [31:0] hdst_mem [0:`TR_HIST_DEPTH-1];
   reg [`TR_HIST_AW-1:0] hwp_ff;
   reg [`TR_HIST_DEPTH-1:0] hval_ff;
   reg [`TR_HIST_AW-1:0] hrd;
   reg lost_ff;
   reg nxt_lost;
   reg wait_ff;
   reg nxt_wait;
   reg nxt_stall;
   reg [71:0] sh_ff;
   reg [4:0] left_ff;
   reg dest_pend_ff;
   reg [31:0] dest_addr_ff;
   reg [31:0] prev_br_ff;
   reg [31:0] prev_win_ff;
   reg br_ok;
   reg [31:0] br_eff_src;
   reg [1:0] hit;
   reg [1:0] win_rec_flags;
   reg [31:0] win_addr;
   reg [31:0] win_data;
   reg win_wr;
   reg win_ok;
   reg [31:0] ca;
   reg [31:0] m;
   reg cv;
   reg cw;
   integer i;
   reg [1:0] n_ev;
   reg [`TR_REC_W-1:0] push_rec;
   reg push_valid;
   reg push_is_info;
   wire push_ready;
   wire [`TR_REC_W-1:0] head;
   wire head_valid;
   wire head_pop;
   wire [FIFO_AW:0] level;
   reg [3:0] ld_type;
   reg [1:0] ld_flags;
   reg [31:0] ld_addr;
   reg [31:0] ld_data;
   reg [1:0] ld_sz;
   reg [3:0] ld_an;
   reg [4:0] ld_len;
   reg [71:0] ld_body;
   wire idle;
   wire ld_avail;

   // Port clock is asynchronous; first stage feeds only the second
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ptc_s1_ff <= 1'b0;
         ptc_s2_ff <= 1'b0;
         ptc_s3_ff <= 1'b0;
      end
      else
      begin
         ptc_s1_ff <= trace_port_clock;
         ptc_s2_ff <= ptc_s1_ff;
         ptc_s3_ff <= ptc_s2_ff;
      end
   end
   assign tick = ptc_s2_ff & ~ptc_s3_ff;

   // Branch filtering and source correction
   always @*
   begin
      br_ok = br_valid & ~br_zero_disp_cond & ~br_reset;
      br_eff_src = br_compl_exc ? br_src + `TR_INSTR_BYTES : br_src;
   end

   // Per-channel range and cycle-type match
   always @*
   begin
      hit = 2'b00;
      ca = 32'h00000000;
      m = 32'hFFFFFFFF;
      cv = 1'b0;
      cw = 1'b0;
      for (i = 0; i < 2; i = i + 1)
      begin
         if (win_sys_bus[i])
         begin
            // cache hits invisible, upper 4 bits dropped
            cv = sb_valid & ~sb_cache_hit;
            cw = sb_write;
            ca = {4'h0, sb_addr};
            m = `TR_SYS_MASK;
         end
         else
         begin
            cv = lb_valid & ~lb_fill;
            cw = lb_write;
            ca = lb_addr;
            m = 32'hFFFFFFFF;
         end
         hit[i] = win_en[i] & cv & (cw ? win_wr_en[i] : win_rd_en[i])
            & ((ca & m) >= (win_lo[32*i +: 32] & m))
            & ((ca & m) <= (win_hi[32*i +: 32] & m));
      end
   end

   // Channel A wins when both channels match
   always @*
   begin
      win_ok = |hit;
      if (hit[0])
      begin
         win_rec_flags = {win_sys_bus[0], 1'b0};
         win_addr = win_sys_bus[0] ? {4'h0, sb_addr} : lb_addr;
         win_data = win_sys_bus[0] ? sb_data : lb_data;
         win_wr = win_sys_bus[0] ? sb_write : lb_write;
      end
      else
      begin
         win_rec_flags = {win_sys_bus[1], 1'b1};
         win_addr = win_sys_bus[1] ? {4'h0, sb_addr} : lb_addr;
         win_data = win_sys_bus[1] ? sb_data : lb_data;
         win_wr = win_sys_bus[1] ? sb_write : lb_write;
      end
   end

   // One record per cycle: branch, then software, then window
   always @*
   begin
      n_ev = {1'b0, br_ok & branch_trace_en} + {1'b0, sw_valid & sw_trace_en}
         + {1'b0, win_ok};
      push_is_info = 1'b0;
      push_valid = 1'b1;
      // event order kept by a single queue
      if (br_ok & branch_trace_en)
         push_rec = {`TR_T_BRANCH, 2'b00, 2'b00, br_eff_src, br_dst};
      else if (sw_valid & sw_trace_en)
         push_rec = {`TR_T_STRACE, 2'b00, 2'b00, sw_pc, sw_reg};
      else if (win_ok)
         push_rec = {win_wr ? `TR_T_WR : `TR_T_RD, 2'b00, win_rec_flags,
            win_addr, win_data};
      else if (wait_ff)
      begin
         push_rec = {`TR_T_WAIT, 4'h0, 64'h0};
         push_is_info = 1'b1;
      end
      else if (lost_ff)
      begin
         push_rec = {`TR_T_LOST, 4'h0, 64'h0};
         push_is_info = 1'b1;
      end
      else
      begin
         push_rec = {`TR_REC_W{1'b0}};
         push_valid = 1'b0;
      end
   end

   // Drop and stall bookkeeping; a new event beats a clear
   always @*
   begin
      nxt_stall = ~realtime_mode
         & ({{(5-FIFO_AW-1){1'b0}}, level} >= FIFO_DEPTH[4:0] - `TR_STALL_SLACK);
      // wait record on each new hold
      nxt_wait = (nxt_stall & ~cpu_stall)
         | (wait_ff & ~(push_is_info & push_ready));
      // lost record on any dropped event
      nxt_lost = ((n_ev > 2'd1) | ((n_ev != 2'd0) & ~push_ready))
         | (lost_ff & ~(push_is_info & push_ready & ~wait_ff));
   end

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cpu_stall <= 1'b0;
         wait_ff <= 1'b0;
         lost_ff <= 1'b0;
      end
      else
      begin
         cpu_stall <= nxt_stall;
         wait_ff <= nxt_wait;
         lost_ff <= nxt_lost;
      end
   end

   trace_fifo #(
      .W(`TR_REC_W),
      .D(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_fifo (
      .clk(clk),
      .rst(rst),
      .in_valid(push_valid),
      .in_data(push_rec),
      .in_ready(push_ready),
      .out_valid(head_valid),
      .out_data(head),
      .out_ready(head_pop),
      .level(level)
   );

   // Next record to serialise: pending destination first
   assign idle = (left_ff == 5'd0);
   assign ld_avail = dest_pend_ff | head_valid;
   assign head_pop = tick & idle & ~dest_pend_ff & head_valid;

   always @*
   begin
      if (dest_pend_ff)
      begin
         ld_type = `TR_T_DEST;
         ld_flags = 2'b00;
         ld_addr = dest_addr_ff;
         ld_data = 32'h00000000;
      end
      else
      begin
         ld_type = head[`TR_TYPE_MSB:`TR_TYPE_LSB];
         ld_flags = head[`TR_FLAG_MSB:`TR_FLAG_LSB];
         ld_addr = head[`TR_ADDR_MSB:`TR_ADDR_LSB];
         ld_data = head[`TR_DATA_MSB:`TR_DATA_LSB];
      end
      // branch source against last branch source
      if (ld_type == `TR_T_BRANCH)
         ld_sz = size_code(ld_addr, prev_br_ff);
      // window address against last window address
      else if ((ld_type == `TR_T_RD) | (ld_type == `TR_T_WR))
         ld_sz = size_code(ld_addr, prev_win_ff);
      else
         ld_sz = `TR_SZ_32;
      // low-part widths from the size code
      ld_an = ((ld_type == `TR_T_LOST) | (ld_type == `TR_T_WAIT)) ? 4'h0
         : addr_nibs(ld_sz);
      ld_len = 5'd2 + {1'b0, ld_an};
      ld_body = ({40'h0, ld_addr} & ~({40'h0, 32'hFFFFFFFF} << {ld_an, 2'b00})) << 8;
      if ((ld_type == `TR_T_RD) | (ld_type == `TR_T_WR) | (ld_type == `TR_T_STRACE))
      begin
         ld_len = ld_len + 5'd8;
         ld_body = ld_body | ({40'h0, ld_data} << {ld_an, 2'b00} << 8);
      end
      ld_body = ld_body | {64'h0, ld_sz, ld_flags, ld_type};
   end

   // Nibble shifter: one nibble per port clock rising edge
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         sh_ff <= 72'h0;
         left_ff <= 5'd0;
         dest_pend_ff <= 1'b0;
         dest_addr_ff <= 32'h00000000;
         prev_br_ff <= 32'h00000000;
         prev_win_ff <= 32'h00000000;
         trace_output_port <= 4'h0;
         trace_sync <= 1'b0;
      end
      else if (tick)
      begin
         if (~idle)
         begin
            trace_output_port <= sh_ff[3:0];
            trace_sync <= 1'b0;
            sh_ff <= sh_ff >> 4;
            left_ff <= left_ff - 5'd1;
         end
         else if (ld_avail)
         begin
            // Header nibble leaves at once, marked by sync
            trace_output_port <= ld_body[3:0];
            trace_sync <= 1'b1;
            sh_ff <= ld_body >> 4;
            left_ff <= ld_len - 5'd1;
            if (~dest_pend_ff & (ld_type == `TR_T_BRANCH))
            begin
               dest_pend_ff <= 1'b1;
               dest_addr_ff <= ld_data;
            end
            else
               dest_pend_ff <= 1'b0;
            if (ld_type == `TR_T_BRANCH)
               prev_br_ff <= ld_addr;
            if ((ld_type == `TR_T_RD) | (ld_type == `TR_T_WR))
               prev_win_ff <= ld_addr;
         end
         else
         begin
            trace_output_port <= 4'h0;
            trace_sync <= 1'b0;
         end
      end
   end

   always @(posedge clk)
   begin
      if (br_ok & int_trace_en)
      begin
         hsrc_mem[hwp_ff] <= br_eff_src;
         hdst_mem[hwp_ff] <= br_dst;
      end
   end

   // Index 0 reads the newest entry
   always @*
   begin
      hrd = hwp_ff - 3'd1 - hist_idx;
   end

   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         hwp_ff <= 3'd0;
         hval_ff <= {`TR_HIST_DEPTH{1'b0}};
         hist_src <= 32'h00000000;
         hist_dst <= 32'h00000000;
      end
      else
      begin
         if (br_ok & int_trace_en)
         begin
            hwp_ff <= hwp_ff + 3'd1;
            hval_ff[hwp_ff] <= 1'b1;
         end
         // Storage has no reset, so unwritten slots are masked to zero
         hist_src <= hval_ff[hrd] ? hsrc_mem[hrd] : 32'h00000000;
         hist_dst <= hval_ff[hrd] ? hdst_mem[hrd] : 32'h00000000;
      end
   end
endmodule // trace_capture

// [tb/trace_capture_chk.sv]
`timescale 1ns/1ns
module trace_capture_chk (
   input wire clk,
   input wire rst,
   input wire trace_port_clock,
   input wire realtime_mode,
   input wire int_trace_en,
   input wire br_valid,
   input wire [31:0] br_src,
   input wire br_zero_disp_cond,
   input wire br_reset,
   input wire br_compl_exc,
   input wire [2:0] hist_idx,
   input wire [31:0] hist_src,
   input wire [3:0] trace_output_port,
   input wire trace_sync,
   input wire cpu_stall
);
   reg pclk_ff;
   reg [3:0] age_ff;
   // Age counter saturates so long idle spans stay quiet
   wire rise = trace_port_clock && !pclk_ff;
   wire [3:0] nxt_age = rise ? 4'h0 : age_ff + {3'h0, age_ff != 4'hF};
   wire idle0 = hist_idx == 3'h0 && !br_valid;
   wire kept = br_valid && int_trace_en && !br_zero_disp_cond && !br_reset && hist_idx == 3'h0;
   // Cycles since the raw port clock last rose
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pclk_ff <= 1'b0;
         age_ff <= 4'hF;
      end
      else
      begin
         pclk_ff <= trace_port_clock;
         age_ff <= nxt_age;
      end
   end
   default clocking dc @(posedge clk); endclocking
   default disable iff (rst);
   tick_paced_a: assert property (
      $changed(trace_output_port) |-> age_ff inside {[4'h1:4'h5]})
      else $error("port nibble moved off a tick");
   sync_type_a: assert property (trace_sync |-> trace_output_port inside {[4'h1:4'h7]})
      else $error("header nibble is not a record type");
   sync_len_a: assert property ($rose(trace_sync) |-> trace_sync [*6] ##[1:4] !trace_sync)
      else $error("header nibble held wrong length");
   rt_nostall_a: assert property (
      realtime_mode && $past(realtime_mode) && !$past(cpu_stall) |-> !cpu_stall)
      else $error("stall raised in realtime mode");
   stall_mode_a: assert property ($rose(cpu_stall) |-> !$past(realtime_mode))
      else $error("stall rose without non-realtime mode");
   hist_src_a: assert property (
      (kept && !br_compl_exc) ##1 idle0 |=> hist_src == $past(br_src, 2))
      else $error("newest history source wrong");
   hist_exc_a: assert property (
      (kept && br_compl_exc) ##1 idle0 |=> hist_src == $past(br_src, 2) + 32'h00000002)
      else $error("exception source not advanced");
   hist_skip_a: assert property (
      (br_valid && (br_zero_disp_cond || br_reset) && hist_idx == 3'h0) ##1 idle0
      |=> $stable(hist_src))
      else $error("filtered branch entered history");
   cover property ($rose(cpu_stall));
   cover property (trace_sync && trace_output_port == 4'h6);
   cover property (trace_sync && trace_output_port == 4'h7);
endmodule // trace_capture_chk

bind trace_capture trace_capture_chk chk_u (.*);

// [tb/trace_probe.sv]
`timescale 1ns/1ns
module trace_probe (
   output logic trace_port_clock,
   input wire logic [3:0] trace_output_port,
   input wire logic trace_sync
);
   logic [71:0] rq[$];
   logic [3:0] typ, n1;
   logic [31:0] a, d;
   int pos = 0, k, na, nd;
   // No JTAG path here, so no test clock is driven
   // Slow port clock
   // Runs free, since the port only advances on its ticks
   initial trace_port_clock = 1'b0;
   always #160 trace_port_clock = ~trace_port_clock;
   // Sample at the falling edge, well after the synchronised update
   always @(negedge trace_port_clock)
   begin
      if (trace_sync === 1'b1)
      begin
         typ = trace_output_port;
         a = 32'h0;
         d = 32'h0;
         k = 0;
         pos = 1;
      end
      else if (pos == 1)
      begin
         n1 = trace_output_port;
         na = (typ > 4'h5) ? 0 : 8 >> n1[3:2];
         nd = (typ > 4'h2 && typ < 4'h6) ? 8 : 0;
         pos = 2;
      end
      else if (pos == 2)
      begin
         if (k < na)
            a[4*k +: 4] = trace_output_port;
         else
            d[4*(k-na) +: 4] = trace_output_port;
         k = k + 1;
      end
      if (pos == 2 && k == na + nd)
      begin
         rq.push_back({typ, n1, a, d});
         pos = 0;
      end
   end
endmodule // trace_probe

// [tb/tb.sv]
`timescale 1ns/1ns
module tb;
   reg clk = 1'b0;
   reg rst = 1'b1;
   reg realtime_mode = 1'b1;
   reg branch_trace_en = 1'b1, sw_trace_en = 1'b1, int_trace_en = 1'b1;
   reg [1:0] win_en = 2'h3, win_rd_en = 2'h3, win_wr_en = 2'h2, win_sys_bus = 2'h2;
   reg [63:0] win_lo = 64'h01000000_00007F00, win_hi = 64'h01FFFFFF_00007FFF;
   reg br_valid = 1'b0, br_zero_disp_cond = 1'b0, br_reset = 1'b0, br_compl_exc = 1'b0;
   reg [31:0] br_src = 32'h0, br_dst = 32'h0, sw_pc = 32'h0, sw_reg = 32'h0;
   reg sw_valid = 1'b0, lb_valid = 1'b0, lb_write = 1'b0, lb_fill = 1'b0;
   reg sb_valid = 1'b0, sb_write = 1'b0, sb_cache_hit = 1'b0;
   reg [31:0] lb_addr = 32'h0, lb_data = 32'h0, sb_data = 32'h0;
   reg [27:0] sb_addr = 28'h0;
   reg [2:0] hist_idx = 3'h0;
   wire [31:0] hist_src, hist_dst;
   wire [3:0] trace_output_port;
   wire trace_sync, cpu_stall, trace_port_clock;
   integer errors = 0, tests_run = 0, i, st;
   integer cnt [0:15];
   reg [31:0] pb = 32'h0, pw = 32'h0;
   reg [71:0] rr;
   reg [159:0] srcs = {32'h80001000, 32'h000012B0, 32'h000012F4, 32'h000011AC, 32'h000011A6};

   trace_capture DUT (.*);
   trace_probe P (.trace_port_clock, .trace_output_port, .trace_sync);

   always #20 clk = ~clk;

   task chk(input [31:0] got, input [31:0] exp);
   begin
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
         errors = errors + 1;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   end
   endtask

   task branch(input [31:0] s, input [31:0] t, input [2:0] q);
   begin
      @(negedge clk);
      {br_src, br_dst} = {s, t};
      {br_zero_disp_cond, br_reset, br_compl_exc} = q;
      br_valid = 1'b1;
      @(negedge clk);
      br_valid = 1'b0;
   end
   endtask

   // One event: 0 software, 1 local bus, 2 system bus
   task ev(input [1:0] k, input w, input f, input [31:0] a, input [31:0] d);
   begin
      @(negedge clk);
      {lb_write, lb_fill, lb_addr, lb_data} = {w, f, a, d};
      {sb_write, sb_cache_hit, sb_addr, sb_data} = {w, f, a[27:0], d};
      {sw_pc, sw_reg} = {a, d};
      {sw_valid, lb_valid, sb_valid} = {k == 2'h0, k == 2'h1, k == 2'h2};
      @(negedge clk);
      {sw_valid, lb_valid, sb_valid} = 3'h0;
   end
   endtask

   // Next record must match; size follows the previous address kept here
   task exp_rec(input [3:0] t, input [1:0] fl, input [31:0] a, input [31:0] d);
      reg [31:0] pv;
      reg [1:0] sz;
      integer n;
   begin
      pv = (t == 4'h1) ? pb : (t == 4'h3 || t == 4'h4) ? pw : ~a;
      sz = (a[31:4] == pv[31:4]) ? 2'h3 : (a[31:8] == pv[31:8]) ? 2'h2 :
         (a[31:16] == pv[31:16]) ? 2'h1 : 2'h0;
      if (t == 4'h1)
         pb = a;
      if (t == 4'h3 || t == 4'h4)
         pw = a;
      n = 0;
      while (P.rq.size() == 0 && n < 800)
      begin
         @(posedge clk);
         n = n + 1;
      end
      rr = (P.rq.size() != 0) ? P.rq.pop_front() : 72'h0;
      chk(rr[71:64], {t, sz, fl});
      chk(rr[63:32], a & ((sz == 2'h0) ? 32'hFFFFFFFF : (32'h1 << (32 >> sz)) - 32'h1));
      chk(rr[31:0], d);
   end
   endtask

   // Count record types until the port stays quiet
   task drain;
      integer n;
   begin
      for (n = 0; n < 16; n = n + 1)
         cnt[n] = 0;
      n = 0;
      while (n < 400)
      begin
         @(posedge clk);
         n = n + 1;
         if (P.rq.size() != 0)
         begin
            rr = P.rq.pop_front();
            cnt[rr[71:68]] = cnt[rr[71:68]] + 1;
            n = 0;
         end
      end
      // Leave on a falling edge, away from output updates
      @(negedge clk);
   end
   endtask

   task complete_run;
   begin
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   end
   endtask

   // Watchdog sized well above the expected run
   initial
   begin
      #2000000;
      errors = errors + 1;
      complete_run;
   end

   initial
   begin
      repeat (20) @(negedge clk);
      rst = 1'b0;
      branch(32'h00005550, 32'h00005000, 3'h4); // Zero displacement skipped
      branch(32'hA0001234, 32'hA0000000, 3'h2); // Reset jump skipped
      for (i = 0; i < 5; i = i + 1)
      begin
         branch(srcs[32*i +: 32], ~srcs[32*i +: 32], 3'h0);
         exp_rec(4'h1, 2'h0, srcs[32*i +: 32], 32'h0); // Every size code
         exp_rec(4'h2, 2'h0, ~srcs[32*i +: 32], 32'h0); // Destination follows
      end
      branch(32'h00003000, 32'h00004000, 3'h1);
      exp_rec(4'h1, 2'h0, 32'h00003002, 32'h0); // Exception source
      exp_rec(4'h2, 2'h0, 32'h00004000, 32'h0);
      for (i = 1; i < 4; i = i + 1)
      begin
         branch(32'h00003000 + 32'h10 * i, 32'h00006000, 3'h0);
         exp_rec(4'h1, 2'h0, 32'h00003000 + 32'h10 * i, 32'h0);
         exp_rec(4'h2, 2'h0, 32'h00006000, 32'h0);
      end
      @(negedge clk);
      hist_idx = 3'h7;
      repeat (2) @(negedge clk);
      chk(hist_src, 32'h000011AC); // Oldest of eight
      chk(hist_dst, ~32'h000011AC);
      hist_idx = 3'h3;
      repeat (2) @(negedge clk);
      chk(hist_src, 32'h00003002); // Adjusted entry kept
      hist_idx = 3'h0;
      $display("branch test done");
      // Disabled sources and a disabled channel leave nothing
      {branch_trace_en, sw_trace_en, int_trace_en, win_en} = 5'h01;
      branch(32'h00009990, 32'h0000999A, 3'h0);
      ev(2'h0, 1'b0, 1'b0, 32'h00009000, 32'h00000001);
      ev(2'h2, 1'b1, 1'b0, 32'h01000010, 32'h00000002);
      {branch_trace_en, sw_trace_en, int_trace_en, win_en} = 5'h1F;
      branch(32'h00003044, 32'h00005000, 3'h0);
      ev(2'h0, 1'b0, 1'b0, 32'h00001234, 32'hCAFE0001);
      ev(2'h1, 1'b0, 1'b0, 32'h00007F58, 32'h00002746);
      ev(2'h1, 1'b1, 1'b0, 32'h00007F9C, 32'h00000003);
      ev(2'h1, 1'b0, 1'b1, 32'h00007F54, 32'h00000004);
      ev(2'h2, 1'b1, 1'b1, 32'h01234560, 32'h00000005);
      ev(2'h2, 1'b1, 1'b0, 32'h01234560, 32'h00001957);
      ev(2'h2, 1'b0, 1'b0, 32'hF1234568, 32'h00007EFF);
      exp_rec(4'h1, 2'h0, 32'h00003044, 32'h0); // Event order kept
      exp_rec(4'h2, 2'h0, 32'h00005000, 32'h0);
      exp_rec(4'h5, 2'h0, 32'h00001234, 32'hCAFE0001); // Software record
      exp_rec(4'h3, 2'h0, 32'h00007F58, 32'h00002746); // Read only, no fill
      exp_rec(4'h4, 2'h3, 32'h01234560, 32'h00001957); // Cache hit skipped
      exp_rec(4'h3, 2'h3, 32'h01234568, 32'h00007EFF); // Upper nibble dropped
      // Channels swap buses: A on system bus with writes, B on local bus
      @(negedge clk);
      {win_sys_bus, win_wr_en} = 4'h5;
      ev(2'h2, 1'b1, 1'b0, 32'h00007F10, 32'h0000ABCD);
      ev(2'h1, 1'b0, 1'b0, 32'h01000020, 32'h00000BAD);
      exp_rec(4'h4, 2'h2, 32'h00007F10, 32'h0000ABCD); // Channel A system bus
      exp_rec(4'h3, 2'h1, 32'h01000020, 32'h00000BAD); // Channel B local bus
      $display("window test done");
      @(negedge clk);
      sw_valid = 1'b1;
      for (i = 0; i < 24; i = i + 1)
      begin
         @(negedge clk);
         sw_pc = sw_pc + 32'h2;
      end
      chk(cpu_stall, 1'b0); // Realtime never holds
      sw_valid = 1'b0;
      drain;
      chk(cnt[6] != 0, 1'b1); // Drop reported
      chk(cnt[5] < 24, 1'b1); // Excess dropped
      $display("realtime test done");
      realtime_mode = 1'b0;
      st = 0;
      for (i = 0; i < 40; i = i + 1)
      begin
         @(negedge clk);
         st = st | (cpu_stall === 1'b1);
         sw_valid = (cpu_stall === 1'b0);
         sw_pc = i;
      end
      @(negedge clk);
      sw_valid = 1'b0;
      chk(st, 1); // CPU held
      drain;
      chk(cnt[7] != 0, 1'b1); // Wait reported
      chk(cnt[6], 0); // Nothing lost
      chk(cpu_stall, 1'b0); // Released after drain
      $display("stall test done");
      complete_run;
   end
endmodule // tb
